// ==== pkg/osrs_regs.svh ====
// Constants: APB register map, field layouts, opcodes and encodings
`ifndef OSRS_REGS_SVH
`define OSRS_REGS_SVH

// ----------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------
`define OSRS_ADDR_INSTR   12'h000
`define OSRS_ADDR_ACC     12'h004
`define OSRS_ADDR_EXT     12'h008
`define OSRS_ADDR_PC      12'h00c
`define OSRS_ADDR_STATUS  12'h010
`define OSRS_ADDR_MADDR   12'h014
`define OSRS_ADDR_MRDATA  12'h018
`define OSRS_ADDR_MWDATA  12'h01c
`define OSRS_ADDR_INDEX0  12'h020
`define OSRS_ADDR_IDX_LO  5'h08
`define OSRS_ADDR_IDX_HI  5'h0f

// ----------------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------------
`define OSRS_F_OP_HI      29
`define OSRS_F_OP_LO      24
`define OSRS_F_SKIP_HI    23
`define OSRS_F_SKIP_LO    21
`define OSRS_F_MOD_HI     20
`define OSRS_F_MOD_LO     18
`define OSRS_F_DST_HI     17
`define OSRS_F_DST_LO     16
`define OSRS_F_ADDR_HI    14
`define OSRS_F_ADDR_LO    0

// ----------------------------------------------------------------------
// Opcodes (octal values as printed)
// ----------------------------------------------------------------------
`define OSRS_OP_ENT_EXT   6'o10
`define OSRS_OP_ENT_ACC   6'o11
`define OSRS_OP_ENT_IDX   6'o12
`define OSRS_OP_STR_EXT   6'o14
`define OSRS_OP_STR_ACC   6'o15
`define OSRS_OP_RPL_ADD1  6'o36
`define OSRS_OP_RPL_SUB1  6'o37
`define OSRS_OP_IDX_SKIP  6'o71

// ----------------------------------------------------------------------
// Operand modifiers, store destinations, skip codes
// ----------------------------------------------------------------------
`define OSRS_MOD_LOW      3'h0
`define OSRS_MOD_UP       3'h1
`define OSRS_MOD_WORD     3'h2
`define OSRS_MOD_LOWX     3'h3
`define OSRS_MOD_UPX      3'h4
`define OSRS_MOD_CLOW     3'h5
`define OSRS_MOD_CUP      3'h6
`define OSRS_MOD_CWORD    3'h7
`define OSRS_DST_MEM      2'h0
`define OSRS_DST_ACC      2'h1
`define OSRS_DST_EXT      2'h2
`define OSRS_SKIP_NONE    3'h0
`define OSRS_SKIP_ALWAYS  3'h1
`define OSRS_SKIP_EXTPOS  3'h2
`define OSRS_SKIP_EXTNEG  3'h3
`define OSRS_SKIP_ACCZ    3'h4
`define OSRS_SKIP_ACCNZ   3'h5
`define OSRS_SKIP_ACCPOS  3'h6
`define OSRS_SKIP_ACCNEG  3'h7

// ----------------------------------------------------------------------
// Widths, sign position, reset values
// ----------------------------------------------------------------------
`define OSRS_SIGN_BIT     29
`define OSRS_HALF_W       15
`define OSRS_ZERO30       30'h0
`define OSRS_ZERO15       15'h0
`define OSRS_ONE15        15'h1
`define OSRS_ONE30        30'h1
`define OSRS_PC_STEP1     15'h1
`define OSRS_PC_STEP2     15'h2
`define OSRS_ST_GO_BIT    0
`define OSRS_ST_BUSY_BIT  1
`define OSRS_ST_SKIP_BIT  2

`endif

// ==== pkg/osrs_pkg.sv ====
// Package: types shared by the operand store/replace/skip unit
package osrs_pkg;

    // Sequencer states, Gray coded along the usual path
    typedef enum logic [2:0] {
        OSRS_IDLE   = 3'b000,
        OSRS_DECODE = 3'b001,
        OSRS_READ   = 3'b011,
        OSRS_EXEC   = 3'b010,
        OSRS_WRITE  = 3'b110,
        OSRS_FINISH = 3'b111
    } osrs_state_t;

endpackage

// ==== logic/osrs_unit.sv ====
// Operand store, replace, enter and skip sequencing unit with APB registers
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "osrs_regs.svh"

module osrs_unit
    import osrs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             memReq,
    output logic             memWrite,
    output logic      [14:0] memAddr,
    output logic      [29:0] memWdata,
    input  wire logic [29:0] memRdata,
    input  wire logic        memAck,
    output logic      [14:0] pcOut,
    output logic             skipTaken
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        osrs_state_t  state;
        logic [29:0]  instr;
        logic [29:0]  acc;
        logic [29:0]  ext;
        logic [14:0]  pc;
        logic [7:0][14:0] idx;
        logic [29:0]  memWord;
        logic [29:0]  result;
        logic         skip;
        logic         busy;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic         memReq;
        logic         memWrite;
        logic [14:0]  memAddr;
        logic [29:0]  memWdata;
    } osrs_core_t;

    osrs_core_t core_reg;
    osrs_core_t core_next;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Read-class operand shaping with half selection and extension
    function automatic logic [29:0] shapeOperand(input logic [2:0]  md,
                                                 input logic [29:0] w);
        logic [14:0] lo;
        logic [14:0] up;
        begin
            lo = w[`OSRS_HALF_W-1:0];
            up = w[29:`OSRS_HALF_W];
            case (md)
                `OSRS_MOD_LOW:  shapeOperand = {`OSRS_ZERO15, lo};
                `OSRS_MOD_UP:   shapeOperand = {`OSRS_ZERO15, up};
                `OSRS_MOD_LOWX: shapeOperand = {{15{lo[14]}}, lo};
                `OSRS_MOD_UPX:  shapeOperand = {{15{up[14]}}, up};
                default:        shapeOperand = w;
            endcase
        end
    endfunction

    // Merge a register value into a memory word per store/replace form
    function automatic logic [29:0] mergeWord(input logic [2:0]  md,
                                              input logic [29:0] old,
                                              input logic [29:0] val);
        logic [29:0] v;
        begin
            v = val;
            if (md == `OSRS_MOD_CLOW || md == `OSRS_MOD_CUP || md == `OSRS_MOD_CWORD) begin
                v = ~val;
            end
            case (md)
                `OSRS_MOD_LOW, `OSRS_MOD_LOWX, `OSRS_MOD_CLOW:
                    mergeWord = {old[29:`OSRS_HALF_W], v[14:0]};
                `OSRS_MOD_UP, `OSRS_MOD_UPX, `OSRS_MOD_CUP:
                    mergeWord = {v[14:0], old[`OSRS_HALF_W-1:0]};
                default:
                    mergeWord = v;
            endcase
        end
    endfunction

    // Whole-word write needs no prior read
    function automatic logic isWholeMod(input logic [2:0] md);
        isWholeMod = (md == `OSRS_MOD_WORD) || (md == `OSRS_MOD_CWORD);
    endfunction

    // Skip condition evaluation, sign is bit 29
    function automatic logic skipCond(input logic [2:0]  code,
                                      input logic [29:0] a,
                                      input logic [29:0] q);
        case (code)
            `OSRS_SKIP_NONE:   skipCond = 1'b0;
            `OSRS_SKIP_ALWAYS: skipCond = 1'b1;
            `OSRS_SKIP_EXTPOS: skipCond = ~q[`OSRS_SIGN_BIT];
            `OSRS_SKIP_EXTNEG: skipCond = q[`OSRS_SIGN_BIT];
            `OSRS_SKIP_ACCZ:   skipCond = (a == `OSRS_ZERO30);
            `OSRS_SKIP_ACCNZ:  skipCond = (a != `OSRS_ZERO30);
            `OSRS_SKIP_ACCPOS: skipCond = ~a[`OSRS_SIGN_BIT];
            default:           skipCond = a[`OSRS_SIGN_BIT];
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [5:0]  op;
        logic [2:0]  sk;
        logic [2:0]  md;
        logic [1:0]  dst;
        logic [29:0] opnd;
        logic [29:0] storeVal;
        logic        isRpl;
        logic        isStore;
        logic        apbAcc;
        logic [2:0]  ridx;
        op        = core_reg.instr[`OSRS_F_OP_HI:`OSRS_F_OP_LO];
        sk        = core_reg.instr[`OSRS_F_SKIP_HI:`OSRS_F_SKIP_LO];
        md        = core_reg.instr[`OSRS_F_MOD_HI:`OSRS_F_MOD_LO];
        dst       = core_reg.instr[`OSRS_F_DST_HI:`OSRS_F_DST_LO];
        opnd      = shapeOperand(md, core_reg.memWord);
        storeVal  = (op == `OSRS_OP_STR_EXT) ? core_reg.ext : core_reg.acc;
        isRpl     = (op == `OSRS_OP_RPL_ADD1) || (op == `OSRS_OP_RPL_SUB1);
        isStore   = (op == `OSRS_OP_STR_EXT) || (op == `OSRS_OP_STR_ACC);
        apbAcc    = psel && penable && !core_reg.pready;
        ridx      = paddr[4:2];
        core_next = core_reg;
        core_next.pready  = 1'b0;
        core_next.pslverr = 1'b0;

        // APB slave, one wait state, answers in access phase
        if (apbAcc) begin
            core_next.pready = 1'b1;
            core_next.prdata = 32'h0;
            if (pwrite) begin
                case (paddr)
                    `OSRS_ADDR_INSTR: begin
                        if (!core_reg.busy) begin
                            core_next.instr = pwdata[29:0];
                            core_next.busy  = 1'b1;
                            core_next.state = OSRS_DECODE;
                        end else begin
                            core_next.pslverr = 1'b1;
                        end
                    end
                    `OSRS_ADDR_ACC: core_next.acc = pwdata[29:0];
                    `OSRS_ADDR_EXT: core_next.ext = pwdata[29:0];
                    `OSRS_ADDR_PC:  core_next.pc  = pwdata[14:0];
                    `OSRS_ADDR_STATUS: core_next.skip = 1'b0;
                    default: begin
                        if (paddr[11:7] == 5'h0 && paddr[6:2] >= `OSRS_ADDR_IDX_LO
                            && paddr[6:2] <= `OSRS_ADDR_IDX_HI) begin
                            core_next.idx[ridx] = pwdata[14:0];
                        end else begin
                            core_next.pslverr = 1'b1;
                        end
                    end
                endcase
            end else begin
                case (paddr)
                    `OSRS_ADDR_INSTR:  core_next.prdata = {2'h0, core_reg.instr};
                    `OSRS_ADDR_ACC:    core_next.prdata = {2'h0, core_reg.acc};
                    `OSRS_ADDR_EXT:    core_next.prdata = {2'h0, core_reg.ext};
                    `OSRS_ADDR_PC:     core_next.prdata = {17'h0, core_reg.pc};
                    `OSRS_ADDR_STATUS: core_next.prdata = {29'h0, core_reg.skip,
                                                           core_reg.busy, 1'b0};
                    `OSRS_ADDR_MADDR:  core_next.prdata = {17'h0, core_reg.memAddr};
                    `OSRS_ADDR_MRDATA: core_next.prdata = {2'h0, core_reg.memWord};
                    `OSRS_ADDR_MWDATA: core_next.prdata = {2'h0, core_reg.memWdata};
                    default: begin
                        if (paddr[11:7] == 5'h0 && paddr[6:2] >= `OSRS_ADDR_IDX_LO
                            && paddr[6:2] <= `OSRS_ADDR_IDX_HI) begin
                            core_next.prdata = {17'h0, core_reg.idx[ridx]};
                        end else begin
                            core_next.pslverr = 1'b1;
                        end
                    end
                endcase
            end
        end

        // Instruction sequencer
        case (core_reg.state)
            OSRS_IDLE: begin
                core_next.memReq = 1'b0;
            end
            OSRS_DECODE: begin
                core_next.memAddr = core_reg.instr[`OSRS_F_ADDR_HI:`OSRS_F_ADDR_LO];
                core_next.skip    = 1'b0;
                if (isStore && dst != `OSRS_DST_MEM) begin
                    core_next.state = OSRS_EXEC;
                end else if (isStore && isWholeMod(md)) begin
                    core_next.memWord  = `OSRS_ZERO30;
                    core_next.state    = OSRS_EXEC;
                end else begin
                    core_next.memReq   = 1'b1;
                    core_next.memWrite = 1'b0;
                    core_next.state    = OSRS_READ;
                end
            end
            OSRS_READ: begin
                if (memAck) begin
                    core_next.memReq  = 1'b0;
                    core_next.memWord = memRdata;
                    core_next.state   = OSRS_EXEC;
                end
            end
            OSRS_EXEC: begin
                core_next.state = OSRS_FINISH;
                case (op)
                    `OSRS_OP_ENT_EXT: core_next.ext = opnd;
                    `OSRS_OP_ENT_ACC: core_next.acc = opnd;
                    `OSRS_OP_ENT_IDX: core_next.idx[sk] = opnd[14:0];
                    `OSRS_OP_IDX_SKIP: begin
                        if ({`OSRS_ZERO15, core_reg.idx[sk]} == opnd) begin
                            core_next.idx[sk] = `OSRS_ZERO15;
                            core_next.result  = `OSRS_ONE30;
                        end else begin
                            core_next.idx[sk] = core_reg.idx[sk] + `OSRS_ONE15;
                            core_next.result  = `OSRS_ZERO30;
                        end
                    end
                    `OSRS_OP_RPL_ADD1, `OSRS_OP_RPL_SUB1: begin
                        core_next.result = (op == `OSRS_OP_RPL_ADD1) ? opnd + `OSRS_ONE30
                                                                     : opnd - `OSRS_ONE30;
                        core_next.acc    = core_next.result;
                    end
                    `OSRS_OP_STR_EXT, `OSRS_OP_STR_ACC: begin
                        if (dst == `OSRS_DST_ACC) begin
                            core_next.acc = storeVal;
                        end else if (dst == `OSRS_DST_EXT) begin
                            core_next.ext = storeVal;
                        end else begin
                            core_next.result = storeVal;
                        end
                    end
                    default: ;
                endcase
                if ((isRpl || isStore) && !(isStore && dst != `OSRS_DST_MEM)) begin
                    core_next.state = OSRS_WRITE;
                end
            end
            OSRS_WRITE: begin
                // Merge the result into the fetched word, then write it whole
                core_next.memWdata = mergeWord(isRpl ? (md == `OSRS_MOD_CWORD ? `OSRS_MOD_WORD
                                               : md) : md, core_reg.memWord,
                                               core_reg.result);
                if (!core_reg.memReq) begin
                    core_next.memReq   = 1'b1;
                    core_next.memWrite = 1'b1;
                end else if (memAck) begin
                    core_next.memReq   = 1'b0;
                    core_next.memWrite = 1'b0;
                    core_next.state    = OSRS_FINISH;
                end
            end
            OSRS_FINISH: begin
                // Skip test on final register contents
                if (op == `OSRS_OP_IDX_SKIP) begin
                    core_next.skip = core_reg.result[0];
                end else if (op != `OSRS_OP_ENT_IDX) begin
                    core_next.skip = skipCond(sk, core_reg.acc, core_reg.ext);
                end
                core_next.pc    = core_reg.pc + (core_next.skip ? `OSRS_PC_STEP2
                                                                : `OSRS_PC_STEP1);
                core_next.busy  = 1'b0;
                core_next.state = OSRS_IDLE;
            end
            default: core_next.state = OSRS_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata    = core_reg.prdata;
    assign pready    = core_reg.pready;
    assign pslverr   = core_reg.pslverr;
    assign memReq    = core_reg.memReq;
    assign memWrite  = core_reg.memWrite;
    assign memAddr   = core_reg.memAddr;
    assign memWdata  = core_reg.memWdata;
    assign pcOut     = core_reg.pc;
    assign skipTaken = core_reg.skip;

endmodule

// ==== verification/osrs_unit_assertions.sv ====
// Checker: port-level properties of the store, replace and skip unit
`timescale 1ns/1ps
module osrs_unit_assertions (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        memReq,
    input wire logic        memWrite,
    input wire logic [14:0] memAddr,
    input wire logic [29:0] memWdata,
    input wire logic [29:0] memRdata,
    input wire logic        memAck,
    input wire logic [14:0] pcOut,
    input wire logic        skipTaken
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // ----------------------------------------------------------------
    // Register bus handshake
    // ----------------------------------------------------------------
    AST_READY_ANSWER: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered next cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error flag without ready");

    // ----------------------------------------------------------------
    // Memory request and program counter
    // ----------------------------------------------------------------
    AST_REQ_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
        && $stable(memWrite) && (!memWrite || $stable(memWdata)))
        else $error("memory request changed before acknowledge");
    AST_REQ_DROP: assert property (memReq && memAck |=> !memReq)
        else $error("memory request kept after acknowledge");
    AST_PC_STEP: assert property (!$stable(pcOut) |->
        pcOut == $past(pcOut) + (skipTaken ? 15'h2 : 15'h1))
        else $error("program counter step wrong");
    AST_SKIP_WITH_PC: assert property ($rose(skipTaken) |-> !$stable(pcOut))
        else $error("skip flagged without counter update");
    AST_RESET_CLEAR: assert property ($fell(srst) |->
        !memReq && !pready && pcOut == 15'h0 && !skipTaken)
        else $error("outputs not cleared by reset");

    COV_WRITE_DONE: cover property (memReq && memWrite && memAck);
    COV_REFUSED: cover property (pslverr);
    COV_SKIP: cover property ($rose(skipTaken));
endmodule

bind osrs_unit osrs_unit_assertions u_chk (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
    .pcOut(pcOut), .skipTaken(skipTaken));

// ==== verification/osrs_mem_model.sv ====
// Partner: word-addressed main memory of 30-bit words
`timescale 1ns/1ps
module osrs_mem_model (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic [14:0] memAddr,
    input  wire logic [29:0] memWdata,
    output logic      [29:0] memRdata,
    output logic             memAck,
    input  wire logic [3:0]  ackDelay
);
    logic [29:0] store [32];
    logic [3:0]  waitCount;

    // Acknowledge after a chosen wait; write lands at the next edge, the one that drops the acknowledge
    always @(posedge clock) begin
        if (srst) begin
            memAck <= 1'b0;
            waitCount <= 4'h0;
        end else if (memAck) begin
            memAck <= 1'b0;
            waitCount <= 4'h0;
            if (memReq && memWrite) begin
                store[memAddr[4:0]] <= memWdata;
            end
        end else if (memReq) begin
            if (waitCount == ackDelay) begin
                memAck <= 1'b1;
            end else begin
                waitCount <= waitCount + 4'h1;
            end
        end
    end

    // Read data only valid while acknowledging, inverted otherwise
    assign memRdata = memAck ? store[memAddr[4:0]] : ~store[memAddr[4:0]];
endmodule

// ==== verification/osrs_unit_test.sv ====
// Testbench: store, replace, enter and skip sequencing over APB
`timescale 1ns/1ps
`include "osrs_regs.svh"
module osrs_unit_test;
    localparam logic [29:0] A0 = {15'h1111, 15'h2222};
    localparam logic [29:0] E0 = {15'h3333, 15'h4444};
    localparam logic [29:0] M1 = {15'h7fff, 15'h7fff};
    localparam logic [29:0] M2 = {15'h0abc, 15'h7fff};
    typedef struct {logic [31:0] instr; logic [29:0] mIn, mExp, aExp, eExp;} osrs_row_t;
    logic        clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  ackDelay = 4'h0;
    logic        pready, pslverr, memReq, memWrite, memAck, skipTaken, err, sk;
    logic [14:0] memAddr, pcOut, pc0;
    logic [29:0] memWdata, memRdata, val;
    osrs_row_t   rows [15];
    int          failures = 0, checked = 0, n;

    always #5 clock = ~clock;

    osrs_unit dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
        .memRdata(memRdata), .memAck(memAck), .pcOut(pcOut), .skipTaken(skipTaken));
    osrs_mem_model mem (.clock(clock), .srst(srst), .memReq(memReq), .memWrite(memWrite),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
        .ackDelay(ackDelay));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] mk(logic [5:0] op, logic [2:0] md,
        logic [1:0] ds = `OSRS_DST_MEM, logic [2:0] j = `OSRS_SKIP_NONE);
        return {2'b00, op, j, md, ds, 1'b0, 15'h5};
    endfunction
    task automatic check(logic ok, string msg);
        checked++;
        if (!ok) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // One APB transfer, held until ready is sampled high
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitIdle();
        int k = 0;
        do begin
            xfer(1'b0, `OSRS_ADDR_STATUS, 32'h0);
            k++;
        end while (rd[1] !== 1'b0 && k < 50);
        check(k < 50, "busy never cleared");
    endtask
    // Run one instruction and check the counter step and skip flag
    task automatic run(logic [31:0] ins, logic s);
        xfer(1'b0, `OSRS_ADDR_PC, 32'h0);
        pc0 = rd[14:0];
        xfer(1'b1, `OSRS_ADDR_INSTR, ins);
        waitIdle();
        check(pcOut === pc0 + (s ? 15'h2 : 15'h1), "pc step");
        check(skipTaken === s, "skip flag");
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rows[0] = '{mk(`OSRS_OP_STR_ACC, `OSRS_MOD_LOW), M1, {15'h7fff, 15'h2222}, A0, E0};
        rows[1] = '{mk(`OSRS_OP_STR_EXT, `OSRS_MOD_UP), M1, {15'h4444, 15'h7fff}, A0, E0};
        rows[2] = '{mk(`OSRS_OP_STR_ACC, `OSRS_MOD_WORD), M1, A0, A0, E0};
        rows[3] = '{mk(`OSRS_OP_STR_ACC, `OSRS_MOD_CLOW), M1, {15'h7fff, 15'h5ddd}, A0, E0};
        rows[4] = '{mk(`OSRS_OP_STR_ACC, `OSRS_MOD_CUP), M1, {15'h5ddd, 15'h7fff}, A0, E0};
        rows[5] = '{mk(`OSRS_OP_STR_EXT, `OSRS_MOD_CWORD), M1, {15'h4ccc, 15'h3bbb}, A0, E0};
        rows[6] = '{mk(`OSRS_OP_STR_ACC, `OSRS_MOD_WORD, `OSRS_DST_EXT), M1, M1, A0, A0};
        rows[7] = '{mk(`OSRS_OP_RPL_ADD1, `OSRS_MOD_LOW), M2, {15'h0abc, 15'h0}, 30'h8000, E0};
        rows[8] = '{mk(`OSRS_OP_RPL_ADD1, `OSRS_MOD_UP), M2, {15'h0abd, 15'h7fff}, 30'h0abd, E0};
        rows[9] = '{mk(`OSRS_OP_RPL_SUB1, `OSRS_MOD_WORD), M2, M2 - 30'h1, M2 - 30'h1, E0};
        rows[10] = '{mk(`OSRS_OP_RPL_SUB1, `OSRS_MOD_LOWX), {15'h0abc, 15'h4000},
            {15'h0abc, 15'h3fff}, {15'h7fff, 15'h3fff}, E0};
        rows[11] = '{mk(`OSRS_OP_RPL_ADD1, `OSRS_MOD_UPX), {15'h4000, 15'h1},
            {15'h4001, 15'h1}, {15'h7fff, 15'h4001}, E0};
        rows[12] = '{mk(`OSRS_OP_ENT_EXT, `OSRS_MOD_WORD), M2, M2, A0, M2};
        rows[13] = '{mk(`OSRS_OP_ENT_ACC, `OSRS_MOD_UP), M2, M2, 30'h0abc, E0};
        rows[14] = '{mk(`OSRS_OP_ENT_ACC, `OSRS_MOD_LOW), M2, M2, 30'h7fff, E0};
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check(pcOut === 15'h0 && skipTaken === 1'b0 && memReq === 1'b0, "reset state");
        // Table of stores, replaces and enters at varied memory speed
        for (int i = 0; i < 15; i++) begin
            ackDelay <= 4'(i % 3);
            xfer(1'b1, `OSRS_ADDR_ACC, {2'b00, A0});
            xfer(1'b1, `OSRS_ADDR_EXT, {2'b00, E0});
            mem.store[5] = rows[i].mIn;
            run(rows[i].instr, 1'b0);
            check(mem.store[5] === rows[i].mExp, "memory word");
            xfer(1'b0, `OSRS_ADDR_ACC, 32'h0);
            check(rd[29:0] === rows[i].aExp, "accumulator");
            xfer(1'b0, `OSRS_ADDR_EXT, 32'h0);
            check(rd[29:0] === rows[i].eExp, "extension");
        end
        $display("test table done");
        // Every skip code against positive and negative values, and zero for codes 0, 1, 4 and 5 only
        for (int c = 0; c < 8; c++) begin
            for (int v = 0; v < 3; v++) begin
                if (v == 2 && c != 0 && c != 1 && c != 4 && c != 5) continue;
                val = (v == 0) ? 30'h1 : (v == 1) ? 30'h2000_0000 : 30'h0;
                mem.store[5] = val;
                sk = (c == 1) | ((c == 2 || c == 6) & !val[29]) | ((c == 3 || c == 7) & val[29])
                    | (c == 4 && val == 30'h0) | (c == 5 && val != 30'h0);
                run(mk((c == 2 || c == 3) ? `OSRS_OP_ENT_EXT : `OSRS_OP_ENT_ACC, `OSRS_MOD_WORD,
                    `OSRS_DST_MEM, 3'(c)), sk);
            end
        end
        $display("test skip codes done");
        // Index load then index skip, equal and unequal
        mem.store[5] = {15'h0abc, 15'h5};
        run(mk(`OSRS_OP_ENT_IDX, `OSRS_MOD_WORD, `OSRS_DST_MEM, 3'h3), 1'b0);
        xfer(1'b0, 12'h02c, 32'h0);
        check(rd === 32'h5, "index load");
        mem.store[5] = 30'h5;
        run(mk(`OSRS_OP_IDX_SKIP, `OSRS_MOD_WORD, `OSRS_DST_MEM, 3'h3), 1'b1);
        xfer(1'b0, 12'h02c, 32'h0);
        check(rd === 32'h0, "index cleared");
        run(mk(`OSRS_OP_IDX_SKIP, `OSRS_MOD_WORD, `OSRS_DST_MEM, 3'h3), 1'b0);
        xfer(1'b0, 12'h02c, 32'h0);
        check(rd === 32'h1, "index increment");
        $display("test index skip done");
        // Refusals: unmapped address and instruction while busy
        xfer(1'b0, 12'h040, 32'h0);
        check(err === 1'b1, "unmapped address");
        ackDelay <= 4'ha;
        xfer(1'b1, `OSRS_ADDR_INSTR, mk(`OSRS_OP_ENT_ACC, `OSRS_MOD_WORD));
        xfer(1'b1, `OSRS_ADDR_INSTR, mk(`OSRS_OP_ENT_ACC, `OSRS_MOD_WORD));
        check(err === 1'b1, "write while busy");
        waitIdle();
        $display("test refusals done");
        summarize();
    end
endmodule
